//--- rtl/dtc_timer_unit.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_unit
   import dtc_pkg::*;
#(
   parameter int PS_DIV_MID = PS_DIV_MID_DEF,
   parameter int PS_DIV_SLOW = PS_DIV_SLOW_DEF
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Core register port
   input wire dtc_sfr_req_t sfrReq,
   output logic [7:0] sfrRdata,
   // Interrupt service acknowledges
   input wire dtc_ack_t svcAck,
   // Count and external interrupt pins
   input wire logic timerACountPin,
   input wire logic timerBCountPin,
   input wire logic extIrqAPin,
   input wire logic extIrqBPin,
   // Flags towards the interrupt controller
   output logic timerAOverflowFlag,
   output logic timerBOverflowFlag,
   output logic extIrqAEdgeFlag,
   output logic extIrqBEdgeFlag
);

   // Register state
   logic [7:0] runFlags_r;
   logic [7:0] runFlags_nxt;
   logic [7:0] modeSel_r;
   logic [PS_USED_W-1:0] prescale_r;
   logic [7:0] sfrRdata_r;
   logic [7:0] rdMux;

   // Address decode
   logic hitRunFlags;
   logic hitModeSel;
   logic hitPrescale;
   logic wrRunFlags;
   logic wrModeSel;
   logic wrPrescale;
   logic [1:0] wrLow;
   logic [1:0] wrHigh;

   // Pins gathered per timer
   logic [1:0] cntPin;
   logic [1:0] extPin;
   logic [1:0] runBit;

   // Cross-timer terms
   logic splitMode;
   logic ovfA;
   logic ovfB;

   // External interrupt pin sampling
   logic [EDGE_STAGES-1:0] extSampA_r;
   logic [EDGE_STAGES-1:0] extSampB_r;
   logic extFallA;
   logic extFallB;

   assign cntPin = {timerBCountPin, timerACountPin};
   assign extPin = {extIrqBPin, extIrqAPin};
   assign runBit = {runFlags_r[RUN_B], runFlags_r[RUN_A]};

   assign hitRunFlags = (sfrReq.addr == ADDR_RUN_FLAGS);
   assign hitModeSel = (sfrReq.addr == ADDR_MODE_SEL);
   assign hitPrescale = (sfrReq.addr == ADDR_PRESCALE);
   assign wrRunFlags = sfrReq.wr & hitRunFlags;
   assign wrModeSel = sfrReq.wr & hitModeSel;
   assign wrPrescale = sfrReq.wr & hitPrescale;
   assign wrLow[0] = sfrReq.wr & (sfrReq.addr == ADDR_T0_LOW);
   assign wrLow[1] = sfrReq.wr & (sfrReq.addr == ADDR_T1_LOW);
   assign wrHigh[0] = sfrReq.wr & (sfrReq.addr == ADDR_T0_HIGH);
   assign wrHigh[1] = sfrReq.wr & (sfrReq.addr == ADDR_T1_HIGH);

   assign splitMode = (dtc_mode_t'(modeSel_r[1:0]) == DTC_MODE_SPLIT);

   // Per-timer prescaler, pin sampling and counter
   for (genvar t = 0; t < 2; t++)
   begin : gTmr
      dtc_tmode_t cfg;
      logic tick;
      logic [EDGE_STAGES-1:0] cntSamp_r;
      logic countFall;
      logic gateOpen;
      logic inc;
      logic incHi;
      logic [7:0] lo_r;
      logic [7:0] hi_r;
      logic [7:0] lo_nxt;
      logic [7:0] hi_nxt;
      logic ovf;
      logic ovfHi;

      assign cfg = dtc_tmode_t'(modeSel_r[MODE_FIELD_W*t +: MODE_FIELD_W]);

      dtc_prescaler #(
         .DIV_MID(PS_DIV_MID),
         .DIV_SLOW(PS_DIV_SLOW)
      ) uPrescale (
         .clock(clock),
         .nrst(nrst),
         .sel(prescale_r[PS_FIELD_W*t +: PS_FIELD_W]), // R16 R17
         .tick(tick)
      );

      // Two samples so a fall needs two machine cycles to be seen
      always_ff @(posedge clock or negedge nrst)
      begin
         if (!nrst)
            cntSamp_r <= '0;
         else
            cntSamp_r <= {cntSamp_r[0], cntPin[t]}; // R3
      end

      // Relies on each pin level lasting at least one cycle
      assign countFall = cntSamp_r[1] & ~cntSamp_r[0]; // R2 R4

      assign gateOpen = ~cfg.gate | extPin[t]; // R5

      // R6
      assign inc = runBit[t] & gateOpen & (cfg.cntSel ? countFall : tick); // R1 R13

      // Split high byte runs from timer A ticks under timer B run
      if (t == 0)
      begin : gSplitHi
         assign incHi = runBit[1] & tick; // R19
      end
      else
      begin : gNoSplitHi
         assign incHi = 1'b0;
      end

      always_comb
      begin
         lo_nxt = lo_r;
         hi_nxt = hi_r;
         ovf = 1'b0;
         ovfHi = 1'b0;
         case (cfg.mode)
            DTC_MODE_13BIT:
            begin
               if (inc)
               begin
                  ovf = &{hi_r, lo_r[MODE0_LOW_W-1:0]};
                  {hi_nxt, lo_nxt[MODE0_LOW_W-1:0]} =
                     {hi_r, lo_r[MODE0_LOW_W-1:0]} + 13'h1; // R7
               end
            end
            DTC_MODE_16BIT:
            begin
               if (inc)
               begin
                  ovf = &{hi_r, lo_r};
                  {hi_nxt, lo_nxt} = {hi_r, lo_r} + 16'h1; // R8
               end
            end
            DTC_MODE_RELOAD:
            begin
               if (inc)
               begin
                  ovf = &lo_r;
                  lo_nxt = ovf ? hi_r : lo_r + 8'h1; // R9
               end
            end
            DTC_MODE_SPLIT:
            begin
               // Timer B simply holds here
               if (t == 0)
               begin
                  if (inc)
                  begin
                     ovf = &lo_r;
                     lo_nxt = lo_r + 8'h1; // R11
                  end
                  if (incHi)
                  begin
                     ovfHi = &hi_r;
                     hi_nxt = hi_r + 8'h1; // R19
                  end
               end
            end // R10
            default:
            begin
               lo_nxt = lo_r;
            end
         endcase
         // Software write wins over a count in the same cycle
         if (wrLow[t])
            lo_nxt = sfrReq.wdata;
         if (wrHigh[t])
            hi_nxt = sfrReq.wdata;
         if (cfg.mode == DTC_MODE_13BIT)
            lo_nxt[7:MODE0_LOW_W] = '0; // R7
      end

      always_ff @(posedge clock or negedge nrst)
      begin
         if (!nrst)
         begin
            lo_r <= RST_COUNT;
            hi_r <= RST_COUNT;
         end
         else
         begin
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
         end
      end
   end

   // Timer B loses its flag to the split high byte
   assign ovfA = gTmr[0].ovf;
   assign ovfB = splitMode ? gTmr[0].ovfHi : gTmr[1].ovf; // R19

   // External interrupt pin sampling
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         // Idle level is high, so a level flag stays clear out of reset
         extSampA_r <= '1;
         extSampB_r <= '1;
      end
      else
      begin
         extSampA_r <= {extSampA_r[0], extIrqAPin};
         extSampB_r <= {extSampB_r[0], extIrqBPin};
      end
   end

   assign extFallA = extSampA_r[1] & ~extSampA_r[0];
   assign extFallB = extSampB_r[1] & ~extSampB_r[0];

   // Hardware sets are applied last so they win over clears
   always_comb
   begin
      runFlags_nxt = runFlags_r;
      if (wrRunFlags)
         runFlags_nxt = sfrReq.wdata;
      if (svcAck.timerA)
         runFlags_nxt[FLAG_A_OVF] = 1'b0; // R12
      if (svcAck.timerB)
         runFlags_nxt[FLAG_B_OVF] = 1'b0; // R12
      if (ovfA)
         runFlags_nxt[FLAG_A_OVF] = 1'b1; // R12
      if (ovfB)
         runFlags_nxt[FLAG_B_OVF] = 1'b1; // R12
      if (runFlags_nxt[EXT_A_TYPE])
      begin
         if (svcAck.extA)
            runFlags_nxt[EXT_A_EDGE] = 1'b0; // R14
         if (extFallA)
            runFlags_nxt[EXT_A_EDGE] = 1'b1; // R14 R18
      end
      else
      begin
         // Level mode: the flag follows a low pin, no latching
         runFlags_nxt[EXT_A_EDGE] = ~extSampA_r[0]; // R15 R18
      end
      if (runFlags_nxt[EXT_B_TYPE])
      begin
         if (svcAck.extB)
            runFlags_nxt[EXT_B_EDGE] = 1'b0; // R14
         if (extFallB)
            runFlags_nxt[EXT_B_EDGE] = 1'b1; // R14 R18
      end
      else
      begin
         runFlags_nxt[EXT_B_EDGE] = ~extSampB_r[0]; // R15 R18
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         runFlags_r <= RST_RUN_FLAGS;
      else
         runFlags_r <= runFlags_nxt;
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         modeSel_r <= RST_MODE_SEL;
      else if (wrModeSel)
         modeSel_r <= sfrReq.wdata;
   end

   // Serial reload field is not kept here and reads zero
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         prescale_r <= RST_PRESCALE;
      else if (wrPrescale)
         prescale_r <= sfrReq.wdata[PS_USED_W-1:0];
   end

   // Read data is registered, valid the cycle after the read strobe
   always_comb
   begin
      case (sfrReq.addr)
         ADDR_RUN_FLAGS: rdMux = runFlags_r;
         ADDR_MODE_SEL: rdMux = modeSel_r;
         ADDR_T0_LOW: rdMux = gTmr[0].lo_r;
         ADDR_T1_LOW: rdMux = gTmr[1].lo_r;
         ADDR_T0_HIGH: rdMux = gTmr[0].hi_r;
         ADDR_T1_HIGH: rdMux = gTmr[1].hi_r;
         ADDR_PRESCALE: rdMux = {{(8-PS_USED_W){1'b0}}, prescale_r};
         default: rdMux = RD_UNMAPPED;
      endcase
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         sfrRdata_r <= RD_UNMAPPED;
      else if (sfrReq.rd)
         sfrRdata_r <= rdMux;
   end

   assign sfrRdata = sfrRdata_r;
   assign timerAOverflowFlag = runFlags_r[FLAG_A_OVF];
   assign timerBOverflowFlag = runFlags_r[FLAG_B_OVF];
   assign extIrqAEdgeFlag = runFlags_r[EXT_A_EDGE];
   assign extIrqBEdgeFlag = runFlags_r[EXT_B_EDGE];

endmodule : dtc_timer_unit
`default_nettype wire

//--- include/dtc_pkg.sv
// What this block does
// R1: Timer mode counts one per prescaled tick.
// R2: Counter mode counts count-pin falling edges.
// R3: Falling edge recognised over two machine cycles.
// R4: Source holds each pin level one cycle.
// R5: Gate set: count only while irq pin high.
// R6: Select bit one counts pin, zero times.
// R7: Mode 00: 13-bit, low byte top zero.
// R8: Mode 01: full 16-bit counter.
// R9: Mode 10: low byte reloads from high.
// R10: Timer B mode 11 stops and holds.
// R11: Timer A mode 11 splits into bytes.
// R12: Overflow sets flag; write or service clears.
// R13: Run bit zero halts the timer.
// R14: Irq pin falling edge sets edge flag.
// R15: Type bit picks edge or low level.
// R16: Timer A prescale: 12, 1, 96.
// R17: Timer B prescale: same encoding, independent.
// R18: Type one is edge, zero is level.
// R19: Split high byte uses timer B run, flag.
package dtc_pkg;

   // Register addresses on the core register port
   localparam logic [7:0] ADDR_RUN_FLAGS = 8'h88;
   localparam logic [7:0] ADDR_MODE_SEL = 8'h89;
   localparam logic [7:0] ADDR_T0_LOW = 8'h8a;
   localparam logic [7:0] ADDR_T1_LOW = 8'h8b;
   localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;
   localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;
   localparam logic [7:0] ADDR_PRESCALE = 8'hd9;

   // Values after reset
   localparam logic [7:0] RST_RUN_FLAGS = 8'h00;
   localparam logic [7:0] RST_MODE_SEL = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [3:0] RST_PRESCALE = 4'h0;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // Run and flags register bit positions
   localparam int FLAG_B_OVF = 7;
   localparam int RUN_B = 6;
   localparam int FLAG_A_OVF = 5;
   localparam int RUN_A = 4;
   localparam int EXT_B_EDGE = 3;
   localparam int EXT_B_TYPE = 2;
   localparam int EXT_A_EDGE = 1;
   localparam int EXT_A_TYPE = 0;

   // Mode select: one 4-bit field per timer, timer A in the low nibble
   localparam int MODE_FIELD_W = 4;
   // Prescale select: one 2-bit field per timer, timer A at bit 0
   localparam int PS_FIELD_W = 2;
   localparam int PS_USED_W = 4;

   // Mode 00 keeps this many low-byte bits
   localparam int MODE0_LOW_W = 5;

   // Count pin sampling depth: a fall is seen after two cycles
   localparam int EDGE_STAGES = 2;

   // Prescale divisors in oscillator periods
   localparam int PS_DIV_FAST_DEF = 1;
   localparam int PS_DIV_MID_DEF = 12;
   localparam int PS_DIV_SLOW_DEF = 96;

   typedef enum logic [1:0] {
      DTC_MODE_13BIT = 2'b00,
      DTC_MODE_16BIT = 2'b01,
      DTC_MODE_RELOAD = 2'b10,
      DTC_MODE_SPLIT = 2'b11
   } dtc_mode_t;

   typedef enum logic [1:0] {
      DTC_PS_DIV12 = 2'b00,
      DTC_PS_DIV1 = 2'b01,
      DTC_PS_DIV96 = 2'b10,
      DTC_PS_RSVD = 2'b11
   } dtc_ps_t;

   typedef struct packed {
      logic gate;
      logic cntSel;
      dtc_mode_t mode;
   } dtc_tmode_t;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } dtc_sfr_req_t;

   typedef struct packed {
      logic timerA;
      logic timerB;
      logic extA;
      logic extB;
   } dtc_ack_t;

endpackage : dtc_pkg

//--- rtl/dtc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_prescaler
   import dtc_pkg::*;
#(
   parameter int DIV_MID = PS_DIV_MID_DEF,
   parameter int DIV_SLOW = PS_DIV_SLOW_DEF
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Divisor select and tick
   input wire logic [1:0] sel,
   output logic tick
);

   localparam int CW = $clog2(DIV_SLOW);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic [CW-1:0] lastCnt;
   logic wrap;

   // Reserved code falls back to the divide-by-12 rate
   always_comb
   begin
      case (dtc_ps_t'(sel))
         DTC_PS_DIV1: lastCnt = CW'(PS_DIV_FAST_DEF - 1);
         DTC_PS_DIV96: lastCnt = CW'(DIV_SLOW - 1);
         default: lastCnt = CW'(DIV_MID - 1);
      endcase
   end

   // Compare with >= so a switch to a faster rate never overshoots
   assign wrap = (cnt_r >= lastCnt);
   assign cnt_nxt = wrap ? '0 : CW'(cnt_r + 1'b1);
   assign tick = wrap;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         cnt_r <= '0;
      else
         cnt_r <= cnt_nxt;
   end

endmodule : dtc_prescaler
`default_nettype wire

//--- tb/dtc_timer_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_unit_checker
   import dtc_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Register port
   input wire dtc_sfr_req_t sfrReq,
   input wire logic [7:0] sfrRdata,
   input wire dtc_ack_t svcAck,
   // Pins and flags
   input wire logic extIrqAPin,
   input wire logic extIrqBPin,
   input wire logic timerAOverflowFlag,
   input wire logic timerBOverflowFlag,
   input wire logic extIrqAEdgeFlag,
   input wire logic extIrqBEdgeFlag
);
   logic [2:0] upCnt_r;
   logic [1:0] modeA_r;
   wire logic wrRf = sfrReq.wr && sfrReq.addr == ADDR_RUN_FLAGS;
   wire logic clrA = wrRf || svcAck.timerA;
   wire logic clrB = wrRf || svcAck.timerB;
   wire logic mapped = sfrReq.addr inside {[8'h88:8'h8d], ADDR_PRESCALE};
   wire logic psWr = sfrReq.wr && sfrReq.addr == ADDR_PRESCALE;
   wire logic psRd = sfrReq.rd && !sfrReq.wr && sfrReq.addr == ADDR_PRESCALE;
   wire logic [3:0] psLow = sfrReq.wdata[3:0];
   // Pin history is too short for the set checks right after reset
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         upCnt_r <= 3'h0;
         modeA_r <= 2'h0;
      end
      else
      begin
         upCnt_r <= upCnt_r[2] ? upCnt_r : upCnt_r + 3'h1;
         modeA_r <= (sfrReq.wr && sfrReq.addr == ADDR_MODE_SEL) ? sfrReq.wdata[1:0] : modeA_r;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   AST_RD_UNMAPPED: assert property (sfrReq.rd && !mapped |=> sfrRdata == RD_UNMAPPED)
      else $error("unmapped read not zero");
   AST_RDATA_HOLD: assert property (!$past(sfrReq.rd) |-> $stable(sfrRdata))
      else $error("read data moved without read");
   AST_PS_READ:
      assert property (psWr ##1 !sfrReq.wr ##1 psRd |=> sfrRdata == {4'h0, $past(psLow, 3)})
      else $error("prescale readback wrong");
   AST_MODE0_LOW:
      assert property (sfrReq.rd && sfrReq.addr == ADDR_T0_LOW && modeA_r == 2'b00
         |=> sfrRdata[7:5] == 3'h0)
      else $error("mode 0 low byte top bits set");
   AST_FLAG_A_CLR: assert property ($fell(timerAOverflowFlag) |-> $past(clrA))
      else $error("flag A cleared without cause");
   AST_FLAG_B_CLR: assert property ($fell(timerBOverflowFlag) |-> $past(clrB))
      else $error("flag B cleared without cause");
   AST_EXT_A_SET:
      assert property (upCnt_r[2] && $rose(extIrqAEdgeFlag) && !$past(wrRf)
         |-> !$past(extIrqAPin, 2) || !$past(extIrqAPin, 3))
      else $error("irq A flag set without low pin");
   AST_EXT_B_SET:
      assert property (upCnt_r[2] && $rose(extIrqBEdgeFlag) && !$past(wrRf)
         |-> !$past(extIrqBPin, 2) || !$past(extIrqBPin, 3))
      else $error("irq B flag set without low pin");
endmodule : dtc_unit_checker
`default_nettype wire

//--- tb/dtc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model
(
   // Clock
   input wire logic clock,
   // Pins towards the timer unit, index 0 is timer A
   output logic [1:0] cntPin,
   output logic [1:0] irqPin
);
   initial
   begin
      cntPin = 2'b11;
      irqPin = 2'b11;
   end
   // Fastest legal rate: each level one full cycle
   task automatic falls(input int t, input int n);
      repeat (n)
      begin
         @(posedge clock);
         cntPin[t] <= 1'b0;
         @(posedge clock);
         cntPin[t] <= 1'b1;
      end
   endtask : falls
   task automatic setIrq(input int t, input logic lvl);
      @(posedge clock);
      irqPin[t] <= lvl;
   endtask : setIrq
endmodule : dtc_pin_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dtc_pkg::*;
   logic clock;
   logic nrst;
   dtc_sfr_req_t sfrReq;
   dtc_ack_t svcAck;
   logic [7:0] sfrRdata;
   logic [1:0] cntPin;
   logic [1:0] irqPin;
   logic [3:0] flags;
   logic [7:0] v;
   int mismatches = 0;
   int checkCount = 0;
   logic [7:0] addrs [7] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hd9};
   // Address, written value, value read back
   logic [23:0] rows [9] = '{24'hd9ff0f, 24'h895a5a, 24'h8bffff, 24'h8c3c3c,
      24'h8dc3c3, 24'h8a7e7e, 24'h890000, 24'h8aff1f, 24'h40ff00};
   int divs [4] = '{12, 1, 96, 12};

   dtc_timer_unit i_dut (.clock(clock), .nrst(nrst), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
      .svcAck(svcAck), .timerACountPin(cntPin[0]), .timerBCountPin(cntPin[1]),
      .extIrqAPin(irqPin[0]), .extIrqBPin(irqPin[1]), .timerAOverflowFlag(flags[3]),
      .timerBOverflowFlag(flags[2]), .extIrqAEdgeFlag(flags[1]), .extIrqBEdgeFlag(flags[0]));
   dtc_pin_model i_pins (.clock(clock), .cntPin(cntPin), .irqPin(irqPin));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checkCount++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      sfrReq <= {a, 2'b10, d};
      @(posedge clock);
      sfrReq.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      sfrReq <= {a, 2'b01, 8'h00};
      @(posedge clock);
      sfrReq.rd <= 1'b0;
      #1 d = sfrRdata;
   endtask : rd
   task automatic ack(input logic [3:0] a);
      @(posedge clock);
      svcAck <= a;
      @(posedge clock);
      svcAck <= 4'h0;
      #1;
   endtask : ack
   task automatic giveVerdict();
      $display("mismatches %0d checks %0d", mismatches, checkCount);
      if (mismatches == 0 && checkCount > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : giveVerdict

   initial
   begin
      repeat (20000) @(posedge clock);
      mismatches++;
      giveVerdict();
   end

   initial
   begin
      sfrReq = '0;
      svcAck = '0;
      nrst = 1'b0;
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      foreach (addrs[i])
      begin
         rd(addrs[i], v);
         check(v, 8'h00);
      end
      foreach (rows[i])
      begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], v);
         check(v, rows[i][7:0]);
      end
      // Window of 192 cycles holds a whole number of ticks for every divisor
      for (int t = 0; t < 2; t++)
         for (int c = 0; c < 4; c++)
         begin
            wr(ADDR_MODE_SEL, 8'h11);
            wr(t ? ADDR_T1_LOW : ADDR_T0_LOW, 8'h00);
            wr(ADDR_PRESCALE, 8'(c << (2 * t)));
            wr(ADDR_RUN_FLAGS, t ? 8'h40 : 8'h10);
            repeat (190) @(posedge clock);
            wr(ADDR_RUN_FLAGS, 8'h00);
            rd(t ? ADDR_T1_LOW : ADDR_T0_LOW, v);
            check(v, 8'(192 / divs[c]));
            repeat (20) @(posedge clock);
            rd(t ? ADDR_T1_LOW : ADDR_T0_LOW, v);
            check(v, 8'(192 / divs[c]));
         end
      for (int m = 0; m < 2; m++)
      begin
         wr(ADDR_MODE_SEL, m ? 8'h00 : 8'h01);
         wr(ADDR_PRESCALE, 8'h01);
         wr(ADDR_T0_LOW, m ? 8'h1f : 8'hff);
         wr(ADDR_T0_HIGH, 8'hff);
         wr(ADDR_RUN_FLAGS, 8'h10);
         repeat (2) @(posedge clock);
         #1 check({7'h00, flags[3]}, 8'h01);
         wr(ADDR_RUN_FLAGS, 8'h00);
         #1 check({7'h00, flags[3]}, 8'h00);
         rd(ADDR_T0_HIGH, v);
         check(v, 8'h00);
         rd(ADDR_T0_LOW, v);
         check(v, 8'h03);
      end
      wr(ADDR_MODE_SEL, 8'h05);
      wr(ADDR_T0_LOW, 8'h00);
      wr(ADDR_RUN_FLAGS, 8'h10);
      i_pins.falls(0, 5);
      repeat (3) @(posedge clock);
      wr(ADDR_RUN_FLAGS, 8'h00);
      rd(ADDR_T0_LOW, v);
      check(v, 8'h05);
      wr(ADDR_MODE_SEL, 8'h0d);
      wr(ADDR_T0_LOW, 8'h00);
      i_pins.setIrq(0, 1'b0);
      wr(ADDR_RUN_FLAGS, 8'h10);
      i_pins.falls(0, 3);
      i_pins.setIrq(0, 1'b1);
      i_pins.falls(0, 3);
      repeat (3) @(posedge clock);
      wr(ADDR_RUN_FLAGS, 8'h00);
      rd(ADDR_T0_LOW, v);
      check(v, 8'h03);
      wr(ADDR_MODE_SEL, 8'h20);
      wr(ADDR_PRESCALE, 8'h04);
      wr(ADDR_T1_HIGH, 8'hfe);
      wr(ADDR_T1_LOW, 8'hfe);
      wr(ADDR_RUN_FLAGS, 8'h40);
      repeat (3) @(posedge clock);
      #1 check({7'h00, flags[2]}, 8'h01);
      wr(ADDR_RUN_FLAGS, 8'h80);
      ack(4'h4);
      check({7'h00, flags[2]}, 8'h00);
      rd(ADDR_T1_LOW, v);
      check(v, 8'hff);
      wr(ADDR_MODE_SEL, 8'h33);
      wr(ADDR_PRESCALE, 8'h05);
      wr(ADDR_T0_LOW, 8'h00);
      wr(ADDR_T0_HIGH, 8'h00);
      wr(ADDR_T1_LOW, 8'h00);
      wr(ADDR_RUN_FLAGS, 8'h10);
      repeat (8) @(posedge clock);
      wr(ADDR_RUN_FLAGS, 8'h40);
      repeat (8) @(posedge clock);
      wr(ADDR_RUN_FLAGS, 8'h00);
      foreach (addrs[i])
         if (i >= 2 && i <= 4)
         begin
            rd(addrs[i], v);
            check(v, i == 3 ? 8'h00 : 8'h0a);
         end
      for (int t = 0; t < 2; t++)
      begin
         wr(ADDR_RUN_FLAGS, t ? 8'h04 : 8'h01);
         i_pins.setIrq(t, 1'b0);
         i_pins.setIrq(t, 1'b1);
         repeat (3) @(posedge clock);
         #1 check({7'h00, flags[1 - t]}, 8'h01);
         ack(4'h2 >> t);
         check({7'h00, flags[1 - t]}, 8'h00);
         wr(ADDR_RUN_FLAGS, 8'h00);
         i_pins.setIrq(t, 1'b0);
         repeat (3) @(posedge clock);
         #1 check({7'h00, flags[1 - t]}, 8'h01);
         i_pins.setIrq(t, 1'b1);
         repeat (3) @(posedge clock);
         #1 check({7'h00, flags[1 - t]}, 8'h00);
      end
      // Reset with both timers stopped: counts gone, no false level flag after release
      @(posedge clock);
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      foreach (addrs[i])
      begin
         rd(addrs[i], v);
         check(v, 8'h00);
      end
      giveVerdict();
   end
endmodule : tb_top

bind dtc_timer_unit dtc_unit_checker i_chk (.clock(clock), .nrst(nrst), .sfrReq(sfrReq),
   .sfrRdata(sfrRdata), .svcAck(svcAck), .extIrqAPin(extIrqAPin), .extIrqBPin(extIrqBPin),
   .timerAOverflowFlag(timerAOverflowFlag), .timerBOverflowFlag(timerBOverflowFlag),
   .extIrqAEdgeFlag(extIrqAEdgeFlag), .extIrqBEdgeFlag(extIrqBEdgeFlag));
`default_nettype wire
